// ### verif/tb_tile_ps_regs.sv
/*
 Self-checking bench for the tile processor-state register group.
 Assumes the design files and tile_ps_consts.svh are on the include path;
 the bench drives every port itself and needs no partner model.
*/
`timescale 1ns/1ps
`include "tile_ps_consts.svh"

`define CHECK(got, exp) begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
end

module tb_tile_ps_regs
    import tile_ps_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic         clk;
    logic         rstn;
    logic         porRstn;
    ps_req_s      psReq;
    logic         psAck_r;
    logic [31:0]  psRdData_r;
    boot_straps_s bootStraps;
    logic [31:0]  otpSecurityWord;
    logic [3:0]   oscTick;
    logic         coreOscEnable_r;
    logic         periphOscEnable_r;
    logic         jtagTapDisable_r;
    logic         globalDebugDisable_r;
    logic         pllJtagBlock_r;
    logic [3:0]   otpSectorLock_r;
    logic         otpMasterLock_r;
    logic         otpRedundancyEnable_r;
    logic         otpBootOverride_r;
    logic         securityWriteLocked_r;
    logic [31:0]  rd;
    int           errors;
    int           n_checks;
    wire  [10:0]  secOut = {securityWriteLocked_r, globalDebugDisable_r, otpMasterLock_r,
                            otpSectorLock_r, otpRedundancyEnable_r, otpBootOverride_r,
                            pllJtagBlock_r, jtagTapDisable_r};

    // Access table: write, fromJtag, address, write data, expected read data
    typedef struct packed {
        logic        wr;
        logic        jtag;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [31:0] exp;
    } row_s;

    localparam row_s ROWS [0:17] = '{
        '{1'b0, 1'b0, 8'h03, 32'h0, 32'h005a012a},
        '{1'b0, 1'b1, 8'h03, 32'h0, 32'h00000000},
        '{1'b0, 1'b0, 8'h05, 32'h0, 32'h00000a31},
        '{1'b1, 1'b0, 8'h03, 32'hffffffff, 32'h0},
        '{1'b0, 1'b0, 8'h03, 32'h0, 32'h005a012a},
        '{1'b1, 1'b0, 8'h05, 32'h00004000, 32'h0},
        '{1'b0, 1'b0, 8'h05, 32'h0, 32'h00004000},
        '{1'b0, 1'b0, 8'h03, 32'h0, 32'h005a002a},
        '{1'b0, 1'b0, 8'h04, 32'h0, 32'h00000000},
        '{1'b1, 1'b0, 8'h06, 32'hffffffff, 32'h0},
        '{1'b0, 1'b0, 8'h06, 32'h0, 32'h00000003},
        '{1'b1, 1'b0, 8'h06, 32'h0, 32'h0},
        '{1'b0, 1'b0, 8'h06, 32'h0, 32'h00000000},
        '{1'b1, 1'b0, 8'h05, 32'hffffffff, 32'h0},
        '{1'b0, 1'b0, 8'h05, 32'h0, 32'h80005fb1},
        '{1'b1, 1'b0, 8'h05, 32'h0, 32'h0},
        '{1'b0, 1'b0, 8'h05, 32'h0, 32'h80005fb1},
        '{1'b0, 1'b0, 8'h0c, 32'h0, 32'h00000000}
    };

    tile_ps_regs dut (
        .clk                   (clk),
        .rstn                  (rstn),
        .porRstn               (porRstn),
        .psReq                 (psReq),
        .psAck_r               (psAck_r),
        .psRdData_r            (psRdData_r),
        .bootStraps            (bootStraps),
        .otpSecurityWord       (otpSecurityWord),
        .oscTick               (oscTick),
        .coreOscEnable_r       (coreOscEnable_r),
        .periphOscEnable_r     (periphOscEnable_r),
        .jtagTapDisable_r      (jtagTapDisable_r),
        .globalDebugDisable_r  (globalDebugDisable_r),
        .pllJtagBlock_r        (pllJtagBlock_r),
        .otpSectorLock_r       (otpSectorLock_r),
        .otpMasterLock_r       (otpMasterLock_r),
        .otpRedundancyEnable_r (otpRedundancyEnable_r),
        .otpBootOverride_r     (otpBootOverride_r),
        .securityWriteLocked_r (securityWriteLocked_r)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One access; the answer is registered on the taking edge and checked just after it
    task automatic access(input logic wr, input logic jtag, input logic [7:0] addr,
                          input logic [31:0] data, output logic [31:0] rdata);
        @(posedge clk);
        psReq <= '{1'b1, wr, jtag, addr, data};
        @(posedge clk);
        psReq.req <= 1'b0;
        #1;
        `CHECK(psAck_r, 1'b1)
        rdata = psRdData_r;
    endtask

    // Ticks held for exactly n counting edges
    task automatic ticks(input logic [3:0] mask, input int n);
        @(posedge clk);
        oscTick <= mask;
        repeat (n) @(posedge clk);
        oscTick <= 4'h0;
    endtask

    task automatic sysReset(input logic por);
        @(posedge clk);
        rstn    <= 1'b0;
        porRstn <= ~por;
        repeat (8) @(posedge clk);
        `CHECK({secOut, coreOscEnable_r, periphOscEnable_r, psAck_r}, 14'h0)
        rstn    <= 1'b1;
        porRstn <= 1'b1;
        @(posedge clk);
        // Let the load edge settle before anyone looks at the outputs
        #1;
    endtask

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // A hang is cut short here and counted as a mismatch
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        summarize();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        errors          = 0;
        n_checks        = 0;
        rstn            = 1'b0;
        porRstn         = 1'b0;
        psReq           = '0;
        oscTick         = 4'h0;
        bootStraps      = '{8'h5a, 1'b1, 1'b0, 1'b1, 1'b0, 2'b10};
        // Reserved bit 30 set on purpose: it must not survive the load
        otpSecurityWord = 32'h40002a31;
        sysReset(1'b1);
        `CHECK(secOut, 11'h0a7)
        foreach (ROWS[i]) begin
            access(ROWS[i].wr, ROWS[i].jtag, ROWS[i].addr, ROWS[i].data, rd);
            `CHECK(rd, ROWS[i].exp)
        end
        `CHECK(secOut, 11'h7ff)
        // Disabled oscillators must not count
        ticks(4'hf, 4);
        access(1'b1, 1'b0, 8'h06, 32'h2, rd);
        `CHECK({coreOscEnable_r, periphOscEnable_r}, 2'b10)
        ticks(4'hf, 5);
        access(1'b1, 1'b0, 8'h06, 32'h1, rd);
        `CHECK({coreOscEnable_r, periphOscEnable_r}, 2'b01)
        ticks(4'hf, 3);
        access(1'b1, 1'b0, 8'h06, 32'h0, rd);
        // Counts hold from the edge after the stop; the ten-cycle wait is margin
        repeat (10) @(posedge clk);
        access(1'b0, 1'b0, 8'h09, 32'h0, rd);
        `CHECK(rd, 32'h3)
        access(1'b0, 1'b0, 8'h0a, 32'h0, rd);
        `CHECK(rd, 32'h3)
        // Back-to-back reads of the two core counters
        @(posedge clk);
        psReq <= '{1'b1, 1'b0, 1'b0, 8'h07, 32'h0};
        @(posedge clk);
        psReq <= '{1'b1, 1'b0, 1'b0, 8'h08, 32'h0};
        #1;
        `CHECK({psAck_r, psRdData_r}, {1'b1, 32'h5})
        @(posedge clk);
        psReq.req <= 1'b0;
        #1;
        `CHECK({psAck_r, psRdData_r}, {1'b1, 32'h5})
        // System reset clears control and the lock but keeps the counts
        access(1'b1, 1'b0, 8'h06, 32'h3, rd);
        sysReset(1'b0);
        access(1'b0, 1'b0, 8'h07, 32'h0, rd);
        `CHECK(rd, 32'h5)
        access(1'b0, 1'b0, 8'h0a, 32'h0, rd);
        `CHECK(rd, 32'h3)
        access(1'b0, 1'b0, 8'h06, 32'h0, rd);
        `CHECK(rd, 32'h0)
        `CHECK(secOut, 11'h0a7)
        access(1'b1, 1'b0, 8'h05, 32'h00004000, rd);
        access(1'b0, 1'b0, 8'h05, 32'h0, rd);
        `CHECK(rd, 32'h00004000)
        `CHECK(secOut, 11'h200)
        summarize();
    end

endmodule // tb_tile_ps_regs

// ### verilog/ring_osc_counter.sv
/*
 One ring oscillator counter. Counts oscillator ticks while enabled.
 Assumes tick is synchronous to clk and porRstn is the power-on reset only.
*/
`timescale 1ns/1ps
`include "tile_ps_consts.svh"

module ring_osc_counter
    import tile_ps_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        clk,
    input  wire logic        porRstn,
    // Oscillator side
    input  wire logic        enable,
    input  wire logic        tick,
    // Count readout
    output logic [15:0]      count
);

    osc_count_s state_r;
    osc_count_s state_nxt;

    always_comb begin
        state_nxt = state_r;
        // System reset does not reach here, so a count survives it
        if (enable && tick) begin // R12
            state_nxt.count = state_r.count + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge porRstn) begin // R15
        if (!porRstn) begin
            state_r.count <= `OSC_COUNT_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign count = state_r.count;

    AST_CNT_HOLD: assert property (@(posedge clk) disable iff (!porRstn) // R14
        !enable |=> $stable(count))
        else $error("Stopped counter moved");

    AST_CNT_STEP: assert property (@(posedge clk) disable iff (!porRstn) // R12
        (enable && tick) |=> (count == $past(count) + 16'h0001))
        else $error("Counter did not step on tick");

endmodule // ring_osc_counter

// ### verilog/tile_ps_consts.svh
/*
 Offsets, field positions, masks and reset values of the tile processor-state
 register group. Assumes inclusion by bare name from both design modules.
*/
// Function
// R1: Boot status read-only; processor number, PLL pins.
// R2: Boot status bits show RAM and JTAG boot.
// R3: Boot status bit 5 shows second core off.
// R4: Boot status bit 4 disables OTP level polling.
// R5: Security register holds copy of OTP word.
// R6: Security bit 31 removes its own write permission.
// R7: Security bit 14 disables global debug access.
// R8: Security bit 0 disables JTAG debug TAP.
// R9: Security bit 4 blocks JTAG boot/PLL access.
// R10: Bits 11:8 lock sectors, bit 12 all.
// R11: Security bit 5 forces OTP boot, mirrored.
// R12: Four free-running oscillators each clock a counter.
// R13: Control bit 1 core, bit 0 peripheral, reset zero.
// R14: Software reads counts only after stopping oscillators.
// R15: Counts in bits 15:0, not system reset.
// R16: Register 0x07 returns tile cell count.
// R17: Register 0x08 returns tile wire count.
// R18: Registers 0x09, 0x0A return peripheral counts.
// R19: Reserved bits ignore writes, read zero.
// R20: Write-disabled security register holds until reset.
`ifndef TILE_PS_CONSTS_SVH
`define TILE_PS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register numbers
// ----------------------------------------------------------------------
`define PS_ADDR_BOOT        8'h03
`define PS_ADDR_SECURITY    8'h05
`define PS_ADDR_OSC_CTRL    8'h06
`define PS_ADDR_OSC_CNT0    8'h07
`define PS_ADDR_OSC_CNT1    8'h08
`define PS_ADDR_OSC_CNT2    8'h09
`define PS_ADDR_OSC_CNT3    8'h0a

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BOOT_OVERRIDE_BIT   8
`define SEC_LOCK_BIT        31
`define SEC_GDEBUG_BIT      14
`define SEC_MASTER_LOCK_BIT 12
`define SEC_SECTOR_LSB      8
`define SEC_REDUNDANCY_BIT  7
`define SEC_OTP_BOOT_BIT    5
`define SEC_PLL_JTAG_BIT    4
`define SEC_TAP_BIT         0
`define OSC_CORE_BIT        1
`define OSC_PERIPH_BIT      0

// ----------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------
`define SEC_WRITE_MASK      32'h80005fb1
`define BOOT_READ_MASK      32'h00ff013f
`define OSC_CTRL_RESET      2'h0
`define OSC_COUNT_RESET     16'h0000
`define OSC_COUNT_W         16
`define OSC_NUM             4

`endif

// ### verilog/tile_ps_pkg.sv
/*
 Types shared by the tile processor-state register group.
 Assumes tile_ps_consts.svh is reachable on the include path.
*/
package tile_ps_pkg;

    typedef enum logic [1:0] {
        PH_LOAD = 2'b01,
        PH_RUN  = 2'b10
    } tile_phase_e;

    // One processor-state access, read or write
    typedef struct packed {
        logic        req;
        logic        write;
        logic        fromJtag;
        logic [7:0]  addr;
        logic [31:0] wrData;
    } ps_req_s;

    // Boot straps sampled after reset release
    typedef struct packed {
        logic [7:0] processorNum;
        logic       secondCorePoweredOff;
        logic       disableOtpPoll;
        logic       bootFromRam;
        logic       bootFromJtag;
        logic [1:0] bootPllPinValue;
    } boot_straps_s;

    typedef struct packed {
        tile_phase_e  phase;
        logic         ack;
        logic [31:0]  rdData;
        boot_straps_s straps;
        logic [31:0]  security;
        logic [1:0]   oscCtrl;
    } tile_state_s;

    typedef struct packed {
        logic [15:0] count;
    } osc_count_s;

endpackage

// ### verilog/tile_ps_regs.sv
/*
 Tile processor-state registers: boot status, security configuration and
 the ring oscillator block. Assumes one access at most per cycle from the
 processor-state instructions, with the answer one cycle later.
*/
`timescale 1ns/1ps
`include "tile_ps_consts.svh"

module tile_ps_regs
    import tile_ps_pkg::*;
(
    // Clock and resets
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        porRstn,
    // Processor-state access
    input  wire ps_req_s     psReq,
    output logic             psAck_r,
    output logic [31:0]      psRdData_r,
    // Boot straps and OTP security word
    input  wire boot_straps_s bootStraps,
    input  wire logic [31:0] otpSecurityWord,
    // Oscillator ticks, one per oscillator
    input  wire logic [3:0]  oscTick,
    // Oscillator enables
    output logic             coreOscEnable_r,
    output logic             periphOscEnable_r,
    // Security controls
    output logic             jtagTapDisable_r,
    output logic             globalDebugDisable_r,
    output logic             pllJtagBlock_r,
    output logic [3:0]       otpSectorLock_r,
    output logic             otpMasterLock_r,
    output logic             otpRedundancyEnable_r,
    output logic             otpBootOverride_r,
    output logic             securityWriteLocked_r
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tile_state_s state_r;
    tile_state_s state_nxt;
    logic [15:0] oscCount [0:3];
    logic [3:0]  oscRun;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic isAccess(input ps_req_s r, input logic [7:0] a,
                                      input logic wr);
        isAccess = r.req && (r.write == wr) && (r.addr == a);
    endfunction

    function automatic logic [31:0] bootWord(input boot_straps_s s,
                                             input logic otpBoot);
        logic [31:0] w;
        w = 32'h00000000;
        w[23:16] = s.processorNum; // R1
        w[1:0] = s.bootPllPinValue; // R1
        w[3] = s.bootFromRam; // R2
        w[2] = s.bootFromJtag; // R2
        w[5] = s.secondCorePoweredOff; // R3
        w[4] = s.disableOtpPoll; // R4
        w[`BOOT_OVERRIDE_BIT] = otpBoot; // R11
        bootWord = w & `BOOT_READ_MASK; // R19
    endfunction

    function automatic logic [31:0] countWord(input logic [15:0] c);
        countWord = {16'h0000, c}; // R15
    endfunction

    // ------------------------------------------------------------------
    // Oscillator counters
    // ------------------------------------------------------------------
    // Counters 0 and 1 are the tile oscillators, 2 and 3 the peripheral ones
    assign oscRun[0] = state_r.oscCtrl[`OSC_CORE_BIT];
    assign oscRun[1] = state_r.oscCtrl[`OSC_CORE_BIT];
    assign oscRun[2] = state_r.oscCtrl[`OSC_PERIPH_BIT];
    assign oscRun[3] = state_r.oscCtrl[`OSC_PERIPH_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < `OSC_NUM; gi = gi + 1) begin : gOsc
            ring_osc_counter uCounter (
                .clk     (clk),
                .porRstn (porRstn),
                .enable  (oscRun[gi]),
                .tick    (oscTick[gi]),
                .count   (oscCount[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        state_nxt.ack = 1'b0;
        state_nxt.rdData = 32'h00000000;
        case (state_r.phase)
            PH_LOAD: begin
                // Straps and OTP word are caught once, after reset release
                state_nxt.straps = bootStraps;
                state_nxt.security = otpSecurityWord & `SEC_WRITE_MASK; // R5
                state_nxt.phase = PH_RUN;
            end
            PH_RUN: begin
                if (psReq.req) begin
                    state_nxt.ack = 1'b1;
                end
                if (isAccess(psReq, `PS_ADDR_SECURITY, 1'b1)
                    && !state_r.security[`SEC_LOCK_BIT]) begin // R6 R20
                    state_nxt.security = psReq.wrData & `SEC_WRITE_MASK; // R19
                end
                if (isAccess(psReq, `PS_ADDR_OSC_CTRL, 1'b1)) begin // R13
                    state_nxt.oscCtrl = psReq.wrData[1:0];
                end
                if (psReq.req && !psReq.write) begin
                    case (psReq.addr)
                        `PS_ADDR_BOOT: begin
                            // A blocked JTAG read sees zero rather than an error
                            if (!(psReq.fromJtag
                                  && state_r.security[`SEC_PLL_JTAG_BIT])) begin // R9
                                state_nxt.rdData = bootWord(state_r.straps,
                                    state_r.security[`SEC_OTP_BOOT_BIT]); // R1
                            end
                        end
                        `PS_ADDR_SECURITY: begin
                            state_nxt.rdData = state_r.security; // R5
                        end
                        `PS_ADDR_OSC_CTRL: begin
                            state_nxt.rdData = {30'h00000000, state_r.oscCtrl}; // R19
                        end
                        `PS_ADDR_OSC_CNT0: begin
                            state_nxt.rdData = countWord(oscCount[0]); // R16
                        end
                        `PS_ADDR_OSC_CNT1: begin
                            state_nxt.rdData = countWord(oscCount[1]); // R17
                        end
                        `PS_ADDR_OSC_CNT2: begin
                            state_nxt.rdData = countWord(oscCount[2]); // R18
                        end
                        `PS_ADDR_OSC_CNT3: begin
                            state_nxt.rdData = countWord(oscCount[3]); // R18
                        end
                        default: begin
                            state_nxt.rdData = 32'h00000000;
                        end
                    endcase
                end
            end
            default: begin
                state_nxt.phase = PH_LOAD;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r.phase <= PH_LOAD;
            state_r.ack <= 1'b0;
            state_r.rdData <= 32'h00000000;
            state_r.straps <= '0;
            state_r.security <= 32'h00000000;
            state_r.oscCtrl <= `OSC_CTRL_RESET; // R13
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign psAck_r = state_r.ack;
    assign psRdData_r = state_r.rdData;
    assign coreOscEnable_r = state_r.oscCtrl[`OSC_CORE_BIT]; // R13
    assign periphOscEnable_r = state_r.oscCtrl[`OSC_PERIPH_BIT]; // R13
    assign jtagTapDisable_r = state_r.security[`SEC_TAP_BIT]; // R8
    assign globalDebugDisable_r = state_r.security[`SEC_GDEBUG_BIT]; // R7
    assign pllJtagBlock_r = state_r.security[`SEC_PLL_JTAG_BIT]; // R9
    assign otpSectorLock_r = state_r.security[`SEC_SECTOR_LSB +: 4]; // R10
    assign otpMasterLock_r = state_r.security[`SEC_MASTER_LOCK_BIT]; // R10
    assign otpRedundancyEnable_r = state_r.security[`SEC_REDUNDANCY_BIT];
    assign otpBootOverride_r = state_r.security[`SEC_OTP_BOOT_BIT]; // R11
    assign securityWriteLocked_r = state_r.security[`SEC_LOCK_BIT]; // R6

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic running;
    assign running = (state_r.phase == PH_RUN);

    AST_ACK_NEXT: assert property (
        (running && psReq.req) |=> psAck_r ##1 !psAck_r || $past(psReq.req))
        else $error("Access not answered in one cycle");

    AST_BOOT_RO: assert property ( // R1
        (running && isAccess(psReq, `PS_ADDR_BOOT, 1'b1)) |=> $stable(state_r.straps))
        else $error("Boot status changed by a write");

    AST_BOOT_FIELDS: assert property ( // R2
        (running && isAccess(psReq, `PS_ADDR_BOOT, 1'b0) && !psReq.fromJtag)
        |=> (psRdData_r[23:16] == $past(state_r.straps.processorNum))
            && (psRdData_r[3:2] == {$past(state_r.straps.bootFromRam),
                                    $past(state_r.straps.bootFromJtag)}))
        else $error("Boot status fields wrong");

    AST_BOOT_OVERRIDE: assert property ( // R11
        (running && isAccess(psReq, `PS_ADDR_BOOT, 1'b0) && !psReq.fromJtag)
        |=> psRdData_r[`BOOT_OVERRIDE_BIT] == $past(otpBootOverride_r))
        else $error("Boot override mirror wrong");

    AST_PLL_JTAG: assert property ( // R9
        (running && isAccess(psReq, `PS_ADDR_BOOT, 1'b0) && psReq.fromJtag
         && pllJtagBlock_r) |=> psRdData_r == 32'h00000000)
        else $error("Blocked JTAG read saw boot status");

    AST_SEC_LOCK: assert property ( // R20
        securityWriteLocked_r |=> securityWriteLocked_r && $stable(state_r.security))
        else $error("Locked security register changed");

    AST_SEC_WRITE: assert property ( // R8
        (running && !securityWriteLocked_r && isAccess(psReq, `PS_ADDR_SECURITY, 1'b1))
        |=> (jtagTapDisable_r == $past(psReq.wrData[0]))
            && (globalDebugDisable_r == $past(psReq.wrData[14])))
        else $error("Security write not taken");

    AST_SEC_RSV: assert property ( // R19
        (running && isAccess(psReq, `PS_ADDR_SECURITY, 1'b0))
        |=> (psRdData_r & ~`SEC_WRITE_MASK) == 32'h00000000)
        else $error("Reserved security bits read nonzero");

    AST_OSC_CTRL: assert property ( // R13
        (running && isAccess(psReq, `PS_ADDR_OSC_CTRL, 1'b1))
        |=> {coreOscEnable_r, periphOscEnable_r} == $past(psReq.wrData[1:0]))
        else $error("Oscillator control not updated");

    AST_CNT_READ: assert property ( // R16
        (running && isAccess(psReq, `PS_ADDR_OSC_CNT0, 1'b0))
        |=> psRdData_r == {16'h0000, $past(oscCount[0])})
        else $error("Tile cell count readout wrong");

    AST_CNT_WIRE: assert property ( // R17
        (running && isAccess(psReq, `PS_ADDR_OSC_CNT1, 1'b0))
        |=> psRdData_r == {16'h0000, $past(oscCount[1])})
        else $error("Tile wire count readout wrong");

    AST_CNT_PCELL: assert property ( // R18
        (running && isAccess(psReq, `PS_ADDR_OSC_CNT2, 1'b0))
        |=> psRdData_r == {16'h0000, $past(oscCount[2])})
        else $error("Peripheral cell count readout wrong");

    AST_CNT_PWIRE: assert property ( // R18
        (running && isAccess(psReq, `PS_ADDR_OSC_CNT3, 1'b0))
        |=> psRdData_r == {16'h0000, $past(oscCount[3])})
        else $error("Peripheral wire count readout wrong");

    AST_PERIPH_HOLD: assert property ( // R13
        !periphOscEnable_r |=> $stable(oscCount[2]) && $stable(oscCount[3]))
        else $error("Stopped peripheral counter moved");

    AST_OSC_RSV: assert property ( // R19
        (running && isAccess(psReq, `PS_ADDR_OSC_CTRL, 1'b0))
        |=> psRdData_r == {30'h0, $past(coreOscEnable_r), $past(periphOscEnable_r)})
        else $error("Oscillator control readback wrong");

    AST_BOOT_FLAGS: assert property ( // R3 R4
        (running && isAccess(psReq, `PS_ADDR_BOOT, 1'b0) && !psReq.fromJtag)
        |=> (psRdData_r[5] == $past(state_r.straps.secondCorePoweredOff))
            && (psRdData_r[4] == $past(state_r.straps.disableOtpPoll)))
        else $error("Boot power or poll flag wrong");

    AST_BOOT_PLL: assert property ( // R1
        (running && isAccess(psReq, `PS_ADDR_BOOT, 1'b0) && !psReq.fromJtag)
        |=> (psRdData_r[1:0] == $past(state_r.straps.bootPllPinValue))
            && ((psRdData_r & ~`BOOT_READ_MASK) == 32'h00000000))
        else $error("Boot pin field or reserved bits wrong");

    AST_JTAG_OPEN: assert property ( // R9
        (running && isAccess(psReq, `PS_ADDR_BOOT, 1'b0) && psReq.fromJtag
         && !pllJtagBlock_r)
        |=> psRdData_r[23:16] == $past(state_r.straps.processorNum))
        else $error("Unblocked JTAG read lost boot status");

    AST_SEC_LOCKS: assert property ( // R9 R10
        (running && !securityWriteLocked_r && isAccess(psReq, `PS_ADDR_SECURITY, 1'b1))
        |=> (otpSectorLock_r == $past(psReq.wrData[11:8]))
            && (otpMasterLock_r == $past(psReq.wrData[12]))
            && (pllJtagBlock_r == $past(psReq.wrData[4])))
        else $error("Lock fields of security write not taken");

    // Checked on entry to run, so the release edge itself never starts an attempt
    AST_SEC_LOAD: assert property ( // R5
        $rose(running) |-> state_r.security == ($past(otpSecurityWord) & `SEC_WRITE_MASK))
        else $error("Security word not copied from OTP");

    COV_SEC_LOCKED_WRITE: cover property (
        securityWriteLocked_r && isAccess(psReq, `PS_ADDR_SECURITY, 1'b1));
    COV_OSC_STOP_READ: cover property (
        coreOscEnable_r ##1 !coreOscEnable_r [*2] ##1
        isAccess(psReq, `PS_ADDR_OSC_CNT1, 1'b0));
    COV_JTAG_BLOCKED: cover property (
        pllJtagBlock_r && psReq.fromJtag && isAccess(psReq, `PS_ADDR_BOOT, 1'b0));
    COV_CNT_BACK_TO_BACK: cover property (
        isAccess(psReq, `PS_ADDR_OSC_CNT0, 1'b0) ##1 isAccess(psReq, `PS_ADDR_OSC_CNT1, 1'b0));
    COV_COUNT_SURVIVES_RESET: cover property (
        $rose(running) && (oscCount[0] != 16'h0000));

endmodule // tile_ps_regs
